/* File: tcs_ctrl.sv */
// control slice of a 16-bit timer: overrides, split mode, aliases, buffer valid
//
// How it works
// - stopped timer: output value bits drive waveform
// - pad needs pin enable; custom logic bypasses
// - split bit selects two 8-bit timers
// - clear alias: writing 1 clears bit
// - set alias: writing 1 sets bit
// - command: none, update, restart, hard reset
// - command field self-clears, always reads zero
// - hard reset ignored while timer enabled
// - unlocked: buffers transfer on update
// - locked: hardware update transfers nothing
// - forced update transfers even when locked
// - direction bit: 0 up, 1 down
// - hardware and software both steer direction
// - compare buffer write sets valid; update clears
// - period buffer write sets valid; update clears
// - auto lock holds lock until enabled valid
// - pin enable lets waveform own the pin
`timescale 1ns/1ps
`include "tcs_defs.svh"
module tcs_ctrl #(
    parameter int NCH = 3
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input tcs_pkg::tcs_bus_s bus_req,
    output logic [7:0] rd_data,
    input wire logic hw_update,
    input wire logic period_buffer_wr,
    input wire logic [NCH-1:0] cmpbuf_wr,
    input wire logic dir_down_evt,
    input wire logic dir_up_evt,
    input wire logic [NCH-1:0] wg_value,
    output tcs_pkg::tcs_strobe_s strobes,
    output logic count_dir,
    output logic lock_update,
    output logic split_mode_select,
    output logic timer_enable,
    output logic [2:0] waveform_mode_select,
    output logic [NCH-1:0] pad_value,
    output logic [NCH-1:0] pad_oe,
    output logic [NCH-1:0] ccl_value
);
    import tcs_pkg::*;

    // write or read hit on one offset
    function automatic logic hit(input tcs_bus_s b, input logic [7:0] ofs, input logic wr);
        return (wr ? b.wr : b.rd) && (b.addr == ofs);
    endfunction

    logic enable_r; // timer running
    logic [NCH-1:0] pin_en_r; // per channel pin output enable
    logic auto_lock_update_r; // auto lock update
    logic [2:0] wgm_r; // waveform mode, passed to datapath
    logic [NCH-1:0] ov_r; // stopped-timer output values
    logic split_r; // split mode select
    logic [1:0] e_q; // {lock update, direction}
    logic [3:0] bv_q; // {chan2..0 valid, period valid}
    logic [7:0] rd_nxt; // read mux
    tcs_strobe_s strobe_r;
    logic [NCH-1:0] pad_r;
    logic [NCH-1:0] oe_r;
    logic [NCH-1:0] ccl_r;

    // decoded writes
    logic wr_a, wr_b, wr_ov, wr_sp, wr_eclr, wr_eset, wr_fclr, wr_fset;
    assign wr_a = hit(bus_req, `TCS_OFS_CTRL_A, 1'b1);
    assign wr_b = hit(bus_req, `TCS_OFS_CTRL_B, 1'b1);
    assign wr_ov = hit(bus_req, `TCS_OFS_OUT_VAL, 1'b1);
    assign wr_sp = hit(bus_req, `TCS_OFS_SPLIT, 1'b1);
    assign wr_eclr = hit(bus_req, `TCS_OFS_CTRLE_CLR, 1'b1);
    assign wr_eset = hit(bus_req, `TCS_OFS_CTRLE_SET, 1'b1);
    assign wr_fclr = hit(bus_req, `TCS_OFS_BV_CLR, 1'b1);
    assign wr_fset = hit(bus_req, `TCS_OFS_BV_SET, 1'b1);

    // command taken from the set alias only; it is never stored
    tcs_cmd_e cmd;
    assign cmd = wr_eset ? tcs_cmd_e'(bus_req.wdata[`TCS_CMD_MSB:`TCS_CMD_LSB])
                         : TCS_CMD_NONE;
    logic force_upd, force_rst, force_hard;
    assign force_upd = (cmd == TCS_CMD_UPDATE);
    assign force_rst = (cmd == TCS_CMD_RESTART);
    assign force_hard = (cmd == TCS_CMD_RESET) && !enable_r;

    // buffer transfer: hardware update only when unlocked, forced always
    logic xfer_now;
    assign xfer_now = (hw_update && !e_q[`TCS_BIT_LOCK_UPDATE]) || force_upd;

    // auto lock: armed when a write turns the auto bit on, or after each transfer
    logic auto_lock_update_on, all_valid, lock_update_set, lock_update_clr;
    assign auto_lock_update_on = wr_b && bus_req.wdata[`TCS_BIT_AUTO_LOCK_UPDATE] && !auto_lock_update_r;
    assign all_valid = &(bv_q[`TCS_BV_MSB:1] | ~pin_en_r);
    assign lock_update_set = auto_lock_update_on || (auto_lock_update_r && xfer_now);
    assign lock_update_clr = auto_lock_update_r && e_q[`TCS_BIT_LOCK_UPDATE] && all_valid;

    // control a, b, output values and split mode
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            enable_r <= 1'b0;
            pin_en_r <= `TCS_RST_CH;
            auto_lock_update_r <= 1'b0;
            wgm_r <= `TCS_RST_CH;
            ov_r <= `TCS_RST_CH;
            split_r <= 1'b0;
        end else begin
            if (wr_a) begin
                enable_r <= bus_req.wdata[`TCS_BIT_ENABLE];
            end
            if (wr_b) begin
                pin_en_r <= bus_req.wdata[`TCS_PEN_MSB:`TCS_PEN_LSB];
                auto_lock_update_r <= bus_req.wdata[`TCS_BIT_AUTO_LOCK_UPDATE];
                wgm_r <= bus_req.wdata[`TCS_WGM_MSB:`TCS_WGM_LSB];
            end
            if (wr_ov) begin
                ov_r <= bus_req.wdata[`TCS_OV_MSB:`TCS_OV_LSB];
            end
            if (wr_sp) begin
                split_r <= bus_req.wdata[`TCS_BIT_SPLIT];
            end
        end
    end

    // lock update and direction behind their alias pair
    tcs_w1sc_reg #(.W(2)) u_ctrl_e (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .sw_set(wr_eset ? bus_req.wdata[1:0] : `TCS_RST_E),
        .sw_clr(wr_eclr ? bus_req.wdata[1:0] : `TCS_RST_E),
        .hw_set({lock_update_set, dir_down_evt}),
        .hw_clr({lock_update_clr | force_hard, dir_up_evt | force_hard}),
        .q(e_q)
    );

    // buffer valid flags; a buffer write beats a same-cycle transfer
    tcs_w1sc_reg #(.W(4)) u_bv (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .sw_set(wr_fset ? bus_req.wdata[3:0] : `TCS_RST_BV),
        .sw_clr(wr_fclr ? bus_req.wdata[3:0] : `TCS_RST_BV),
        .hw_set({cmpbuf_wr, period_buffer_wr}),
        .hw_clr({4{xfer_now | force_hard}}),
        .q(bv_q)
    );

    // strobes to the datapath, one cycle after their cause
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            strobe_r <= '0;
        end else begin
            strobe_r.xfer <= xfer_now;
            strobe_r.restart <= force_rst;
            strobe_r.hard_reset <= force_hard;
        end
    end

    // waveform outputs: running timer drives, stopped timer uses override
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            pad_r <= `TCS_RST_CH;
            oe_r <= `TCS_RST_CH;
            ccl_r <= `TCS_RST_CH;
        end else begin
            // custom logic sees the value whatever the pin enable
            ccl_r <= enable_r ? wg_value : ov_r;
            // a disabled pin carries nothing of the waveform
            pad_r <= (enable_r ? wg_value : ov_r) & pin_en_r;
            oe_r <= pin_en_r;
        end
    end

    // read mux; both aliases show the same bits, command reads zero
    always_comb begin
        rd_nxt = `TCS_RST_BYTE;
        unique case (bus_req.addr)
            `TCS_OFS_CTRL_A: rd_nxt[`TCS_BIT_ENABLE] = enable_r;
            `TCS_OFS_CTRL_B: begin
                rd_nxt[`TCS_PEN_MSB:`TCS_PEN_LSB] = pin_en_r;
                rd_nxt[`TCS_BIT_AUTO_LOCK_UPDATE] = auto_lock_update_r;
                rd_nxt[`TCS_WGM_MSB:`TCS_WGM_LSB] = wgm_r;
            end
            `TCS_OFS_OUT_VAL: rd_nxt[`TCS_OV_MSB:`TCS_OV_LSB] = ov_r;
            `TCS_OFS_SPLIT: rd_nxt[`TCS_BIT_SPLIT] = split_r;
            `TCS_OFS_CTRLE_CLR, `TCS_OFS_CTRLE_SET: rd_nxt[1:0] = e_q;
            `TCS_OFS_BV_CLR, `TCS_OFS_BV_SET: rd_nxt[3:0] = bv_q;
            default: rd_nxt = `TCS_RST_BYTE; // unmapped reads zero
        endcase
    end

    // read data stand only in the cycle after the strobe
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            rd_data <= `TCS_RST_BYTE;
        end else begin
            rd_data <= bus_req.rd ? rd_nxt : `TCS_RST_BYTE;
        end
    end

    assign strobes = strobe_r;
    assign count_dir = e_q[`TCS_BIT_DIR];
    assign lock_update = e_q[`TCS_BIT_LOCK_UPDATE];
    assign split_mode_select = split_r;
    assign timer_enable = enable_r;
    assign waveform_mode_select = wgm_r;
    assign pad_value = pad_r;
    assign pad_oe = oe_r;
    assign ccl_value = ccl_r;

    // checks next to the logic they guard
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);

    sequence s_force_upd;
        wr_eset && bus_req.wdata[`TCS_CMD_MSB:`TCS_CMD_LSB] == 2'h1;
    endsequence

    sequence s_locked_hw;
        hw_update && lock_update && !wr_eset;
    endsequence

    // hard reset asked for while running and while stopped
    sequence s_hard_run;
        wr_eset && bus_req.wdata[`TCS_CMD_MSB:`TCS_CMD_LSB] == 2'h3 && timer_enable;
    endsequence

    sequence s_hard_stop;
        wr_eset && bus_req.wdata[`TCS_CMD_MSB:`TCS_CMD_LSB] == 2'h3 && !timer_enable;
    endsequence

    // auto lock may let go: every enabled channel valid and nothing sets it
    sequence s_auto_ready;
        auto_lock_update_r && lock_update && all_valid && !xfer_now
            && !(wr_eset && bus_req.wdata[`TCS_BIT_LOCK_UPDATE]);
    endsequence

    cmd_reads_zero_a: assert property (
        bus_req.rd && (bus_req.addr == `TCS_OFS_CTRLE_SET
        || bus_req.addr == `TCS_OFS_CTRLE_CLR) |=> rd_data[3:2] == 2'h0)
        else $error("command field read back nonzero");

    hard_reset_gate_a: assert property (s_hard_run |=> !strobes.hard_reset)
        else $error("hard reset taken while timer enabled");

    hard_reset_take_a: assert property (s_hard_stop |=> strobes.hard_reset)
        else $error("hard reset lost while timer stopped");

    restart_strobe_a: assert property (
        wr_eset && bus_req.wdata[`TCS_CMD_MSB:`TCS_CMD_LSB] == 2'h2 |=> strobes.restart)
        else $error("forced restart not passed on");

    forced_update_a: assert property (s_force_upd |=> strobes.xfer)
        else $error("forced update did not transfer");

    lock_blocks_a: assert property (s_locked_hw |=> !strobes.xfer)
        else $error("locked update transferred buffers");

    unlocked_xfer_a: assert property (
        hw_update && !lock_update && !wr_fset
        |=> strobes.xfer && bv_q == {$past(cmpbuf_wr), $past(period_buffer_wr)})
        else $error("unlocked update missed transfer");

    clear_alias_a: assert property (
        wr_eclr && bus_req.wdata[`TCS_BIT_DIR] && !dir_down_evt |=> !count_dir)
        else $error("clear alias left direction set");

    set_alias_a: assert property (wr_eset && bus_req.wdata[`TCS_BIT_DIR] |=> count_dir)
        else $error("set alias failed to set direction");

    buffer_valid_a: assert property (
        cmpbuf_wr[0] |=> bv_q[1] ##1 (bv_q[1] || $past(xfer_now) || $past(wr_fclr)
        || $past(force_hard)))
        else $error("compare buffer valid not held");

    period_valid_a: assert property (period_buffer_wr |=> bv_q[0])
        else $error("period buffer valid not set");

    pad_gate_a: assert property (
        pad_value != '0 |-> ($past(pin_en_r) & pad_value) == pad_value)
        else $error("pad driven without pin enable");

    override_val_a: assert property (
        !timer_enable && $stable(timer_enable) |=> ccl_value == $past(ov_r))
        else $error("stopped timer ignored output value");

    split_set_a: assert property (
        wr_sp && bus_req.wdata[`TCS_BIT_SPLIT] |=> split_mode_select)
        else $error("split mode bit not taken");

    dir_down_a: assert property (dir_down_evt |=> count_dir)
        else $error("hardware down event ignored");

    dir_up_a: assert property (
        dir_up_evt && !dir_down_evt && !(wr_eset && bus_req.wdata[`TCS_BIT_DIR])
        |=> !count_dir)
        else $error("hardware up event ignored");

    auto_release_a: assert property (s_auto_ready |=> !lock_update)
        else $error("auto lock held with all buffers valid");

    auto_relock_a: assert property (auto_lock_update_r && xfer_now |=> lock_update)
        else $error("auto lock not set again after transfer");

    reset_zero_a: assert property (
        disable iff (1'b0) !rst_b |=> {lock_update, count_dir, split_mode_select,
        timer_enable, strobes, rd_data, pad_value, pad_oe, ccl_value} == '0)
        else $error("output not zero after reset");

endmodule // tcs_ctrl

/* File: tcs_ctrl_tb.sv */
// self-checking testbench of the timer control slice
`timescale 1ns/1ps
`include "tcs_defs.svh"
`define CHK(got, exp) begin total_checks++; if ((got) !== (exp)) begin fail_count++; \
    $display("[ERR] %0t got %0h expected %0h", $time, got, exp); end end
module test_tcs_ctrl;
    import tcs_pkg::*;
    logic core_clk = 1'b0; // bench clock, 4 ns period
    logic rst_b = 1'b0; // held low for three edges
    tcs_bus_s bus_req = '0; // register port request
    logic [7:0] rd_data;
    logic hw_update = 1'b0;
    logic period_buffer_wr = 1'b0;
    logic [2:0] cmpbuf_wr = 3'h0;
    logic dir_down_evt = 1'b0;
    logic dir_up_evt = 1'b0;
    logic [2:0] wg_value = 3'h0;
    tcs_strobe_s strobes;
    logic count_dir, lock_update, split_mode_select, timer_enable;
    logic [2:0] waveform_mode_select, pad_value, pad_oe, ccl_value;
    int fail_count = 0; // mismatches seen
    int total_checks = 0; // comparisons made
    logic [7:0] exp_q[$]; // expected read data, oldest first
    logic [7:0] exp_v; // note taken off the queue
    logic rd_q = 1'b0; // a read was taken at the last edge

    tcs_ctrl #(.NCH(3)) tcs_ctrl_inst (.core_clk(core_clk), .rst_b(rst_b), .bus_req(bus_req),
        .rd_data(rd_data), .hw_update(hw_update), .period_buffer_wr(period_buffer_wr),
        .cmpbuf_wr(cmpbuf_wr), .dir_down_evt(dir_down_evt), .dir_up_evt(dir_up_evt),
        .wg_value(wg_value), .strobes(strobes), .count_dir(count_dir),
        .lock_update(lock_update), .split_mode_select(split_mode_select),
        .timer_enable(timer_enable), .waveform_mode_select(waveform_mode_select),
        .pad_value(pad_value), .pad_oe(pad_oe), .ccl_value(ccl_value));

    // free-running clock
    always #2 core_clk = ~core_clk;

    // read data stands only in the cycle after the strobe, so look mid-cycle
    always @(posedge core_clk) rd_q <= bus_req.rd;
    always @(negedge core_clk) begin
        if (rd_q) begin
            exp_v = exp_q.pop_front();
            `CHK(rd_data, exp_v)
        end
    end

    // verdict and end of run, shared with the watchdog
    task automatic give_verdict();
        if (fail_count == 0 && total_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // one-cycle write; returns just after the taking edge has landed
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge core_clk);
        bus_req.wr <= 1'b0;
        #1;
    endtask

    // one-cycle read; the monitor compares the answer
    task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        exp_q.push_back(e);
        @(posedge core_clk);
        bus_req.rd <= 1'b0;
        #1;
    endtask

    // datapath pulses: {down, up, update, period write, compare writes}
    task automatic dp(input logic [6:0] v);
        @(posedge core_clk);
        {dir_down_evt, dir_up_evt, hw_update, period_buffer_wr, cmpbuf_wr} <= v;
        @(posedge core_clk);
        {dir_down_evt, dir_up_evt, hw_update, period_buffer_wr, cmpbuf_wr} <= 7'h00;
        #1;
    endtask

    // watchdog: the sequence needs well under a thousand cycles
    initial begin
        #20000;
        fail_count++;
        give_verdict();
    end

    // main sequence
    initial begin
        logic [7:0] v;
        void'($urandom(32'hE401CEE1));
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        #1;
        `CHK({count_dir, lock_update, split_mode_select, timer_enable}, 4'h0)
        for (int a = 3; a < 8; a++) rd_reg(a[7:0], 8'h00);
        // set and clear aliases share one register
        wr_reg(`TCS_OFS_CTRLE_SET, 8'h03);
        `CHK(count_dir, 1'b1)
        rd_reg(`TCS_OFS_CTRLE_CLR, 8'h03);
        rd_reg(`TCS_OFS_CTRLE_SET, 8'h03);
        wr_reg(`TCS_OFS_CTRLE_CLR, 8'h01);
        `CHK(count_dir, 1'b0)
        rd_reg(`TCS_OFS_CTRLE_SET, 8'h02);
        wr_reg(`TCS_OFS_CTRLE_CLR, 8'h02);
        dp(7'h40);
        `CHK(count_dir, 1'b1)
        dp(7'h20);
        `CHK(count_dir, 1'b0)
        // buffer writes raise their valid flags
        v = 8'($urandom);
        dp({3'h0, v[0], v[3:1]});
        rd_reg(`TCS_OFS_BV_CLR, {4'h0, v[3:0]});
        wr_reg(`TCS_OFS_BV_SET, 8'h0F);
        wr_reg(`TCS_OFS_BV_CLR, 8'h05);
        rd_reg(`TCS_OFS_BV_SET, 8'h0A);
        // locked: hardware update moves nothing, forced update does
        wr_reg(`TCS_OFS_CTRLE_SET, 8'h02);
        dp(7'h10);
        `CHK(strobes, 3'h0)
        rd_reg(`TCS_OFS_BV_SET, 8'h0A);
        wr_reg(`TCS_OFS_CTRLE_SET, 8'h04);
        `CHK(strobes, 3'h4)
        rd_reg(`TCS_OFS_CTRLE_SET, 8'h02);
        rd_reg(`TCS_OFS_BV_SET, 8'h00);
        wr_reg(`TCS_OFS_CTRLE_CLR, 8'h02);
        dp(7'h02);
        dp(7'h10);
        `CHK(strobes, 3'h4)
        rd_reg(`TCS_OFS_BV_CLR, 8'h00);
        wr_reg(`TCS_OFS_CTRLE_SET, 8'h08);
        `CHK(strobes, 3'h2)
        rd_reg(`TCS_OFS_CTRLE_CLR, 8'h00);
        // hard reset only while stopped
        wr_reg(`TCS_OFS_CTRLE_SET, 8'h03);
        wr_reg(`TCS_OFS_BV_SET, 8'h0F);
        wr_reg(`TCS_OFS_CTRL_A, 8'h01);
        `CHK(timer_enable, 1'b1)
        wr_reg(`TCS_OFS_CTRLE_SET, 8'h0C);
        `CHK(strobes, 3'h0)
        rd_reg(`TCS_OFS_CTRLE_SET, 8'h03);
        wr_reg(`TCS_OFS_CTRL_A, 8'h00);
        wr_reg(`TCS_OFS_CTRLE_SET, 8'h0C);
        `CHK(strobes, 3'h1)
        rd_reg(`TCS_OFS_CTRLE_SET, 8'h00);
        rd_reg(`TCS_OFS_BV_SET, 8'h00);
        // output overrides while stopped, gated by pin enables
        v = 8'($urandom);
        @(posedge core_clk) wg_value <= 3'($urandom);
        wr_reg(`TCS_OFS_CTRL_B, {1'b0, v[6:4], 1'b0, v[2:0]});
        wr_reg(`TCS_OFS_OUT_VAL, {5'h00, v[2:0]});
        repeat (2) @(posedge core_clk);
        #1;
        `CHK(pad_value, v[2:0] & v[6:4])
        `CHK(ccl_value, v[2:0])
        `CHK(pad_oe, v[6:4])
        `CHK(waveform_mode_select, v[2:0])
        // running timer: waveform values reach pads through pin enables
        wr_reg(`TCS_OFS_CTRL_A, 8'h01);
        repeat (2) @(posedge core_clk);
        #1;
        `CHK(pad_value, wg_value & v[6:4])
        `CHK(ccl_value, wg_value)
        wr_reg(`TCS_OFS_CTRL_A, 8'h00);
        // split mode level
        wr_reg(`TCS_OFS_SPLIT, 8'h01);
        `CHK(split_mode_select, 1'b1)
        rd_reg(`TCS_OFS_SPLIT, 8'h01);
        // auto lock: held until channel 0 valid, set again after transfer
        wr_reg(`TCS_OFS_CTRL_B, 8'h18);
        repeat (2) @(posedge core_clk);
        #1;
        `CHK(lock_update, 1'b1)
        dp(7'h01);
        repeat (2) @(posedge core_clk);
        #1;
        `CHK(lock_update, 1'b0)
        dp(7'h10);
        `CHK(strobes, 3'h4)
        repeat (2) @(posedge core_clk);
        #1;
        `CHK(lock_update, 1'b1)
        // unmapped place reads zero and takes no write
        wr_reg(8'h10, 8'hFF);
        rd_reg(8'h10, 8'h00);
        rd_reg(`TCS_OFS_SPLIT, 8'h01);
        // a second reset in mid-run clears what was set above
        @(posedge core_clk) rst_b <= 1'b0;
        repeat (3) @(posedge core_clk);
        rst_b <= 1'b1;
        #1;
        `CHK({lock_update, split_mode_select, pad_oe}, 5'h00)
        rd_reg(`TCS_OFS_CTRL_B, 8'h00);
        rd_reg(`TCS_OFS_BV_SET, 8'h00);
        repeat (3) @(posedge core_clk);
        `CHK(exp_q.size(), 0)
        give_verdict();
    end
endmodule // test_tcs_ctrl

/* File: tcs_defs.svh */
// register offsets, field positions and reset values of the timer control slice
`ifndef TCS_DEFS_SVH
`define TCS_DEFS_SVH

// register offsets on the plain register port
`define TCS_OFS_CTRL_A 8'h00
`define TCS_OFS_CTRL_B 8'h01
`define TCS_OFS_OUT_VAL 8'h02
`define TCS_OFS_SPLIT 8'h03
`define TCS_OFS_CTRLE_CLR 8'h04
`define TCS_OFS_CTRLE_SET 8'h05
`define TCS_OFS_BV_CLR 8'h06
`define TCS_OFS_BV_SET 8'h07

// field positions
`define TCS_BIT_ENABLE 0
`define TCS_BIT_SPLIT 0
`define TCS_BIT_DIR 0
`define TCS_BIT_LOCK_UPDATE 1
`define TCS_CMD_LSB 2
`define TCS_CMD_MSB 3
`define TCS_BIT_AUTO_LOCK_UPDATE 3
`define TCS_WGM_LSB 0
`define TCS_WGM_MSB 2
`define TCS_PEN_LSB 4
`define TCS_PEN_MSB 6
`define TCS_OV_LSB 0
`define TCS_OV_MSB 2
`define TCS_BV_MSB 3

// reset values
`define TCS_RST_BYTE 8'h00
`define TCS_RST_CH 3'h0
`define TCS_RST_BV 4'h0
`define TCS_RST_E 2'h0

`endif

/* File: tcs_pkg.sv */
// types shared by the timer control slice
package tcs_pkg;

    // command field codes of the control e aliases
    typedef enum logic [1:0] {
        TCS_CMD_NONE = 2'h0,
        TCS_CMD_UPDATE = 2'h1,
        TCS_CMD_RESTART = 2'h2,
        TCS_CMD_RESET = 2'h3
    } tcs_cmd_e;

    // one register port request
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } tcs_bus_s;

    // one-cycle strobes toward the counting datapath
    typedef struct packed {
        logic xfer;
        logic restart;
        logic hard_reset;
    } tcs_strobe_s;

endpackage

/* File: tcs_w1sc_reg.sv */
// bit register with set and clear alias writes plus hardware set and clear
`timescale 1ns/1ps
module tcs_w1sc_reg #(
    parameter int W = 4
) (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic [W-1:0] sw_set,
    input wire logic [W-1:0] sw_clr,
    input wire logic [W-1:0] hw_set,
    input wire logic [W-1:0] hw_clr,
    output logic [W-1:0] q
);

    // sets win over clears so no event is lost in a clearing cycle
    always_ff @(posedge core_clk) begin
        if (!rst_b) begin
            q <= '0;
        end else begin
            q <= (q & ~(sw_clr | hw_clr)) | sw_set | hw_set;
        end
    end

endmodule // tcs_w1sc_reg
